// ---- design/iol_defs.vh ----
// constants for the or-immediate / or-file / load-immediate decoder
`ifndef IOL_DEFS_VH
`define IOL_DEFS_VH
`define IOL_OPC_W 14
`define IOL_OPC_OR_IMM 6'h38
`define IOL_OPC_OR_FILE 6'h04
`define IOL_OPC_LOAD_IMM 4'hc
`define IOL_DEST_BIT 7
`define IOL_PH_Q1 4'h1
`define IOL_PH_Q2 4'h2
`define IOL_PH_Q3 4'h4
`define IOL_PH_Q4 4'h8
`define IOL_ACC_RST 8'h00
`define IOL_ZERO_RST 1'b0
`endif

// ---- design/iol_alu.v ----
// or / pass-through unit with zero detect
`timescale 1ns/1ns
module iol_alu #(
   parameter WIDTH = 8
) (
   input wire [WIDTH-1:0] a_i,
   input wire [WIDTH-1:0] b_i,
   input wire pass_b_i,
   output wire [WIDTH-1:0] res_o,
   output wire zero_o
);
   // pass b for literal load, otherwise or
   assign res_o = pass_b_i ? b_i : (a_i | b_i);
   // zero flag candidate
   assign zero_o = (res_o == {WIDTH{1'b0}});
endmodule // iol_alu

// ---- design/iol_core.v ----
// decoder and datapath for or-immediate, or-file and load-immediate
// Notes on behaviour
// - or-immediate ors accumulator with literal byte
// - or-immediate opcode is 11 1000 kkkk kkkk
// - or-immediate writes accumulator, updates zero, one cycle
// - or-file opcode 00 0100 dfff ffff, updates zero
// - dest bit zero accumulator, one file
`timescale 1ns/1ns
`include "iol_defs.vh"
module iol_core #(
   parameter DATA_W = 8,
   parameter ADDR_W = 7
) (
   input wire clk_i,
   input wire reset_n_i,
   input wire [13:0] opcode_i,
   input wire opcode_valid_i,
   input wire [DATA_W-1:0] file_rdata_i,
   output reg [ADDR_W-1:0] file_addr_o,
   output reg [DATA_W-1:0] file_wdata_o,
   output reg file_we_o,
   output reg [DATA_W-1:0] acc_o,
   output reg zero_flag_o,
   output reg [3:0] phase_o,
   output reg illegal_o
);
   // one word is taken per four clocks, and only in q1; a valid level
   // in any other phase is ignored, so the caller may hold it high.
   // the word and the file byte come from logic on this clock, so
   // neither passes a synchroniser; file_rdata_i must stand at the
   // edge that ends q2. a word that decodes as none of the three runs
   // all four phases, raises illegal_o, loads file_addr_o from its low bits and writes nothing else.

   // reset synchroniser: the pin clears both stages at once, and the
   // release reaches the logic two edges later, so no register leaves
   // reset on an edge too close to the pin's rise
   reg rst_s1_q;
   reg rst_s2_q;
   wire rst_n;
   always @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // decode helpers, shared by the phase logic
   // only the top bits are compared; address, destination and literal
   // fields are don't-care here
   function is_or_imm;
      input [13:0] op;
      is_or_imm = (op[13:8] == `IOL_OPC_OR_IMM);
   endfunction
   function is_or_file;
      input [13:0] op;
      is_or_file = (op[13:8] == `IOL_OPC_OR_FILE);
   endfunction
   function is_load_imm;
      input [13:0] op;
      // the two don't-care bits are ignored on decode
      is_load_imm = (op[13:10] == `IOL_OPC_LOAD_IMM);
   endfunction

   // instruction latched at q1, held for the whole cycle
   reg [13:0] ir_q;
   reg [DATA_W-1:0] opnd_q; // literal or file byte read in q2
   wire [DATA_W-1:0] alu_res;
   wire alu_zero;
   wire dec_or_imm;
   wire dec_or_file;
   wire dec_load;
   assign dec_or_imm = is_or_imm(ir_q);
   assign dec_or_file = is_or_file(ir_q);
   assign dec_load = is_load_imm(ir_q);

   // shared or unit; literal load just passes the operand
   // one unit for all three forms costs a mux, not a second datapath
   iol_alu #(
      .WIDTH(DATA_W)
   ) u_alu (
      .a_i(acc_o),
      .b_i(opnd_q),
      .pass_b_i(dec_load),
      .res_o(alu_res),
      .zero_o(alu_zero)
   );

   // next value of every register but the two reset stages, all worked out in one process
   reg [3:0] phase_d; // one-hot phase after this edge
   reg [13:0] ir_d; // held instruction word
   reg [DATA_W-1:0] opnd_d; // operand for the or unit
   reg [ADDR_W-1:0] addr_d; // file address from the word
   reg [DATA_W-1:0] wdata_d; // byte for a file write-back
   reg we_d; // file write strobe, one clock
   reg [DATA_W-1:0] acc_d; // accumulator
   reg zero_d; // result-zero flag
   reg illegal_d; // last taken word was none of the three
   wire take_word; // a word is accepted on this edge
   wire take_illegal; // the offered word decodes as none of the three

   // valid is ignored outside q1, so a long valid level takes one word per four clocks
   assign take_word = (phase_o == `IOL_PH_Q1) && opcode_valid_i;
   // decode of the offered word, before it reaches ir_q
   assign take_illegal = !(is_or_imm(opcode_i) || is_or_file(opcode_i)
      || is_load_imm(opcode_i));

   // four-phase instruction cycle: decode, read, process, write
   always @*
   begin
      // hold by default; an unknown word then writes nothing
      phase_d = phase_o;
      ir_d = ir_q;
      opnd_d = opnd_q;
      addr_d = file_addr_o;
      wdata_d = file_wdata_o;
      we_d = 1'b0; // strobe drops unless q4 raises it
      acc_d = acc_o;
      zero_d = zero_flag_o;
      illegal_d = illegal_o;
      case (phase_o)
         `IOL_PH_Q1:
         begin
            // decode; stall here until a word is offered
            if (take_word)
            begin
               ir_d = opcode_i;
               // the file byte is addressed early so it stands by q2
               addr_d = opcode_i[ADDR_W-1:0];
               illegal_d = take_illegal;
               phase_d = `IOL_PH_Q2;
            end
         end
         `IOL_PH_Q2:
         begin
            // literal from the word, else the addressed file byte
            if (dec_or_file)
               opnd_d = file_rdata_i;
            else
               opnd_d = ir_q[DATA_W-1:0];
            phase_d = `IOL_PH_Q3;
         end
         `IOL_PH_Q3:
         begin
            // or unit settles from opnd_q; only the phase moves
            phase_d = `IOL_PH_Q4;
         end
         `IOL_PH_Q4:
         begin
            // write back, one instruction cycle total
            if (dec_or_imm)
            begin
               // accumulator and flag both follow the result
               acc_d = alu_res;
               zero_d = alu_zero;
            end
            else if (dec_or_file)
            begin
               // flag follows the result for either destination
               zero_d = alu_zero;
               if (ir_q[`IOL_DEST_BIT])
               begin
                  // back into the addressed byte, accumulator kept
                  wdata_d = alu_res;
                  we_d = 1'b1;
               end
               else
                  acc_d = alu_res;
            end
            else if (dec_load)
               acc_d = alu_res;
            // an unknown word falls through and changes nothing
            phase_d = `IOL_PH_Q1;
         end
         default:
            // broken one-hot code: restart at q1 rather than lock up
            phase_d = `IOL_PH_Q1;
      endcase
   end

   // the write strobe stands for the one clock after q4; the file must
   // take the byte on the edge that ends it, which comes before the next
   // q2 read, so back-to-back words see the new byte
   // registers load their next value on every edge
   always @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // idle values: q1, empty accumulator, flag clear, no write
         phase_o <= `IOL_PH_Q1;
         ir_q <= 14'h0000;
         opnd_q <= {DATA_W{1'b0}};
         file_addr_o <= {ADDR_W{1'b0}};
         file_wdata_o <= {DATA_W{1'b0}};
         file_we_o <= 1'b0;
         acc_o <= `IOL_ACC_RST;
         zero_flag_o <= `IOL_ZERO_RST;
         illegal_o <= 1'b0;
      end
      else
      begin
         phase_o <= phase_d;
         ir_q <= ir_d;
         opnd_q <= opnd_d;
         file_addr_o <= addr_d;
         file_wdata_o <= wdata_d;
         file_we_o <= we_d;
         acc_o <= acc_d;
         zero_flag_o <= zero_d;
         illegal_o <= illegal_d;
      end
   end
endmodule // iol_core

// ---- testbench/iol_core_sva.sv ----
// port assertions for the or / load decoder
`timescale 1ns/1ns
module iol_core_sva (
   input wire clk_i,
   input wire reset_n_i,
   input wire [13:0] opcode_i,
   input wire opcode_valid_i,
   input wire [7:0] file_rdata_i,
   input wire [7:0] file_wdata_o,
   input wire file_we_o,
   input wire [7:0] acc_o,
   input wire zero_flag_o,
   input wire [3:0] phase_o
);
   // word taken only in q1
   wire tk = phase_o == 4'h1 && opcode_valid_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   load_imm_a: assert property (
      tk && opcode_i[13:10] == 4'hc
         |-> ##4 acc_o == $past(opcode_i[7:0], 4) && $stable(zero_flag_o))
      else $error("load result wrong");
   or_imm_a: assert property (
      tk && opcode_i[13:8] == 6'h38 |-> ##4 acc_o == ($past(acc_o, 4) | $past(opcode_i[7:0], 4)))
      else $error("or literal result wrong");
   imm_zero_a: assert property (
      tk && opcode_i[13:8] == 6'h38 |-> ##4 zero_flag_o == (acc_o == 8'h00))
      else $error("or literal zero wrong");
   file_acc_a: assert property (
      tk && opcode_i[13:7] == 7'h08 |-> ##4 acc_o == ($past(acc_o, 4) | $past(file_rdata_i, 3)))
      else $error("or file result wrong");
   file_dest_a: assert property (
      tk && opcode_i[13:7] == 7'h09 |-> ##4 file_we_o && $stable(acc_o))
      else $error("or file destination wrong");
   we_pulse_a: assert property (file_we_o |=> !file_we_o)
      else $error("write strobe too long");
   file_wdata_a: assert property (
      tk && opcode_i[13:7] == 7'h09
         |-> ##4 file_wdata_o == ($past(acc_o, 4) | $past(file_rdata_i, 3))
         && zero_flag_o == (file_wdata_o == 8'h00))
      else $error("or file write data wrong");
   bad_word_a: assert property (
      tk && opcode_i[13:8] != 6'h38 && opcode_i[13:8] != 6'h04 && opcode_i[13:10] != 4'hc
         |-> ##4 acc_o == $past(acc_o, 4) && zero_flag_o == $past(zero_flag_o, 4) && !file_we_o)
      else $error("unknown word changed state");
   phase_walk_a: assert property (
      phase_o == 4'h2 |=> phase_o == 4'h4 ##1 phase_o == 4'h8 ##1 phase_o == 4'h1)
      else $error("instruction cycle not four phases");
endmodule // iol_core_sva
bind iol_core iol_core_sva i_sva (.*);

// ---- testbench/tb_top.sv ----
// bench for the or / load decoder
`timescale 1ns/1ns
module tb_top;
   reg clk_i = 0, reset_n_i = 0, vld = 0;
   reg [13:0] opc = 0;
   reg [7:0] rd = 0;
   wire [7:0] acc, wd;
   wire [6:0] adr;
   wire z, we, ill;
   wire [3:0] ph;
   integer failures = 0, check_count = 0, cyc = 0;
   iol_core i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .opcode_i(opc), .opcode_valid_i(vld),
      .file_rdata_i(rd), .file_addr_o(adr), .file_wdata_o(wd), .file_we_o(we), .acc_o(acc),
      .zero_flag_o(z), .phase_o(ph), .illegal_o(ill));
   initial forever #4 clk_i = ~clk_i;
   // compare one value
   task chk(input [8*3:1] n, input [7:0] e, s);
      begin
         check_count = check_count + 1;
         if (s !== e)
         begin
            failures = failures + 1;
            $display("unexpected %s exp %h seen %h", n, e, s);
         end
      end
   endtask
   // wait for q1, offer the word for one edge, judge while the q4 write stands
   task step(input [13:0] op, input [7:0] r, ea, input ez, ew);
      begin
         @(negedge clk_i);
         while (ph !== 4'h1)
            @(negedge clk_i);
         @(posedge clk_i);
         opc <= op;
         rd <= r;
         vld <= 1'b1;
         @(posedge clk_i);
         vld <= 1'b0;
         repeat (3) @(posedge clk_i);
         @(negedge clk_i);
         chk("acc", ea, acc);
         chk("z", {7'h0, ez}, {7'h0, z});
         chk("we", {7'h0, ew}, {7'h0, we});
         chk("ph", 8'h01, {4'h0, ph});
         chk("adr", {1'b0, op[6:0]}, {1'b0, adr});
      end
   endtask
   // literal forms, zero flag kept by loads
   task t_lit;
      begin
         step(14'h309a, 8'h00, 8'h9a, 1'b0, 1'b0);
         step(14'h3835, 8'h00, 8'hbf, 1'b0, 1'b0);
         step(14'h3300, 8'h00, 8'h00, 1'b0, 1'b0);
         step(14'h3800, 8'h00, 8'h00, 1'b1, 1'b0);
         step(14'h3091, 8'h00, 8'h91, 1'b1, 1'b0);
      end
   endtask
   // file forms, both destinations
   task t_file;
      begin
         step(14'h0413, 8'h13, 8'h93, 1'b0, 1'b0);
         step(14'h3000, 8'h00, 8'h00, 1'b0, 1'b0);
         step(14'h0493, 8'h13, 8'h00, 1'b0, 1'b1);
         chk("wd", 8'h13, wd);
         step(14'h0480, 8'h00, 8'h00, 1'b1, 1'b1);
         chk("wd", 8'h00, wd);
      end
   endtask
   // near-miss words are refused, a legal one clears the level
   task t_bad;
      begin
         step(14'h3900, 8'h00, 8'h00, 1'b1, 1'b0);
         chk("ill", 8'h01, {7'h0, ill});
         step(14'h3855, 8'h00, 8'h55, 1'b0, 1'b0);
         chk("ill", 8'h00, {7'h0, ill});
         step(14'h0500, 8'haa, 8'h55, 1'b0, 1'b0);
         chk("ill", 8'h01, {7'h0, ill});
      end
   endtask
   // reset in mid-run returns the outputs to idle, then a word still works
   task t_reset;
      begin
         @(posedge clk_i);
         reset_n_i <= 1'b0;
         @(posedge clk_i);
         @(negedge clk_i);
         chk("acc", 8'h00, acc);
         chk("z", 8'h00, {7'h0, z});
         chk("ph", 8'h01, {4'h0, ph});
         chk("ill", 8'h00, {7'h0, ill});
         chk("we", 8'h00, {7'h0, we});
         @(posedge clk_i);
         reset_n_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         step(14'h3800, 8'h00, 8'h00, 1'b1, 1'b0);
      end
   endtask
   // verdict and end of run
   task report_and_stop;
      begin
         if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         failures = failures + 1;
         report_and_stop;
      end
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      t_lit;
      t_file;
      t_bad;
      t_reset;
      report_and_stop;
   end
endmodule // tb_top
